//--- include/jdb_defs.svh
// Function
// - Four break points, four configurable layouts
// - Also halt on flow change and single step
// - Debugger injects CPU instructions via scan chain
// - Debug needs both fuses and no lock bits
// - Opcodes 8 to B are private debug ops
// - CPU write stores byte and sets dirty
// - CPU read returns seven bits plus dirty
// - Dirty clears once debugger fetched the byte
// - Shared address reaches mailbox only when enabled
// - Port active: enable fuse set, disable bit clear
// - Flash, EEPROM, fuses, locks programmed over port
// - Locked part refuses debug fuse until erase
// - Identification is the default loaded instruction
// - Device reset floats every port pin output, except under external test
// - Reset from pin low or reset register
// - External test drives latches, samples pins
// - Sample/preload snapshots pins without disturbing them
// - Boundary scan runs from the system clock, sampling test clock edges
// - Bypass is one stage, cleared at capture
// - Chain drives and observes all port pins
// - Four mandatory instructions plus device reset
// - Instruction register four bits, LSB first
// - Codes: ext 0, id 1, sample 2, reset C, bypass F
// - Reset register unlatched, TAP not reset
// - Standard sixteen-state TAP, starts in reset state
`ifndef JDB_DEFS_SVH
`define JDB_DEFS_SVH

`define JDB_IR_WIDTH      4
`define JDB_IR_EXTEST     4'h0
`define JDB_IR_IDCODE     4'h1
`define JDB_IR_SAMPLE     4'h2
`define JDB_IR_DBG_OP0    4'h8
`define JDB_IR_DBG_OP1    4'h9
`define JDB_IR_DBG_OP2    4'hA
`define JDB_IR_DBG_OP3    4'hB
`define JDB_IR_DEV_RESET  4'hC
`define JDB_IR_BYPASS     4'hF
`define JDB_IR_CAPTURE    4'h1

`define JDB_CPU_INSTR_W   16
`define JDB_COMM_W        9
`define JDB_BP_CFG_W      70
`define JDB_PROG_W        24
`define JDB_BP_MODE_LSB   64
`define JDB_BP_RANGE_DATA 66
`define JDB_BP_FLOW_EN    67
`define JDB_BP_STEP_EN    68
`define JDB_BP_COMM_EN    69

`define JDB_BP_MODE_4P    2'h0
`define JDB_BP_MODE_3P1D  2'h1
`define JDB_BP_MODE_2P2D  2'h2
`define JDB_BP_MODE_RANGE 2'h3

`define JDB_CMD_CHIP_ERASE 8'h80
`define JDB_CMD_DBG_FUSE   8'h40

`endif

//--- include/jdb_pkg.sv
package jdb_pkg;

  // Standard test access port state encoding
  typedef enum logic [3:0] {
    ST_EXIT2_DR  = 4'h0,
    ST_EXIT1_DR  = 4'h1,
    ST_SHIFT_DR  = 4'h2,
    ST_PAUSE_DR  = 4'h3,
    ST_SEL_IR    = 4'h4,
    ST_UPDATE_DR = 4'h5,
    ST_CAPT_DR   = 4'h6,
    ST_SEL_DR    = 4'h7,
    ST_EXIT2_IR  = 4'h8,
    ST_EXIT1_IR  = 4'h9,
    ST_SHIFT_IR  = 4'hA,
    ST_PAUSE_IR  = 4'hB,
    ST_IDLE      = 4'hC,
    ST_UPDATE_IR = 4'hD,
    ST_CAPT_IR   = 4'hE,
    ST_TLR       = 4'hF
  } jdb_tap_state_type;

endpackage

//--- verilog/jdb_sync.sv
`timescale 1ns/100ps
module jdb_sync import jdb_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // Two stages; the first is read by the second alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

//--- verilog/jdb_tap.sv
`timescale 1ns/100ps
`include "jdb_defs.svh"
module jdb_tap import jdb_pkg::*; #(
  parameter int          PIN_COUNT = 8,
  parameter logic [31:0] ID_VALUE  = 32'h1234_5671  // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Test access pins
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdo_oe_n,
  // Fuses, lock bits and control bit
  input  wire logic                 test_port_enable_fuse,
  input  wire logic                 debug_enable_fuse,
  input  wire logic                 lock_bit_one,
  input  wire logic                 lock_bit_two,
  input  wire logic                 test_port_disable_bit,
  // Reset pin and device reset
  input  wire logic                 ext_reset_n,
  output logic                      dev_reset,
  // Port pins and core side of the pins
  input  wire logic [PIN_COUNT-1:0] pin_in,
  input  wire logic [PIN_COUNT-1:0] core_out,
  input  wire logic [PIN_COUNT-1:0] core_oe,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe_n,
  // CPU access to the mailbox address
  input  wire logic                 cpu_comm_wr,
  input  wire logic                 cpu_comm_rd,
  input  wire logic [7:0]           cpu_comm_wdata,
  output logic      [7:0]           cpu_comm_rdata,
  output logic                      io_ordinary_wr,
  output logic                      io_ordinary_rd,
  // CPU instruction injection and break point inputs
  output logic      [15:0]          cpu_instr,
  output logic                      cpu_instr_valid,
  input  wire logic [15:0]          cpu_pc,
  input  wire logic                 cpu_fetch,
  input  wire logic                 cpu_flow_change,
  input  wire logic [15:0]          cpu_daddr,
  input  wire logic                 cpu_dvalid,
  output logic                      break_req,
  // Programming path to the memory controller
  output logic      [7:0]           prog_cmd,
  output logic      [15:0]          prog_data,
  output logic                      prog_valid,
  output logic                      prog_refused
);

  localparam int BSR_W = 3 * PIN_COUNT;

  logic [2:0]               pin_sync;
  logic                     tck_s, tms_s, tdi_s, rst_n_s, tck_d;
  logic [PIN_COUNT-1:0]     pin_s;
  logic                     tck_rise, tck_fall;
  jdb_tap_state_type        state, next_state;
  logic [3:0]               ir, ir_sr, eff_ir;
  logic                     port_active, debug_active, locked;
  logic                     bypass_sr, rst_sr;
  logic [31:0]              id_sr;
  logic [BSR_W-1:0]         bsr, bsr_cap;
  logic [PIN_COUNT-1:0]     ul_dat, ul_ctl;
  logic [15:0]              cpu_sr;
  logic [8:0]               comm_sr;
  logic [`JDB_BP_CFG_W-1:0] bp_sr, bp_cfg;
  logic [`JDB_PROG_W-1:0]   prog_sr;
  logic [7:0]               comm_byte;
  logic                     dirty, erased;
  logic                     capt_dr, shift_dr, upd_dr, next_tdo;
  logic                     extest_on, dev_rst_int, comm_route;
  logic [1:0]               bp_mode;
  logic [3:0]               bp_hit;
  logic                     range_hit;

  // Pins, reset pin and the test clock come from outside this clock domain
  jdb_sync #(.WIDTH(3)) u_sync_tap (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({tck, tms, tdi}),
    .sync_out (pin_sync)
  );
  jdb_sync #(.WIDTH(PIN_COUNT + 1)) u_sync_pins (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({ext_reset_n, pin_in}),
    .sync_out ({rst_n_s, pin_s})
  );
  assign tck_s = pin_sync[2];
  assign tms_s = pin_sync[1];
  assign tdi_s = pin_sync[0];

  // Test clock edges; the system clock must outrun the test clock by four or more
  always_ff @(posedge clk) begin
    if (sys_rst) tck_d <= 1'b0;
    else tck_d <= tck_s;
  end
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // Port and debug enables
  assign port_active  = test_port_enable_fuse & ~test_port_disable_bit;
  assign locked       = lock_bit_one | lock_bit_two;
  assign debug_active = port_active & debug_enable_fuse & ~locked;

  // Standard state transitions on the mode-select input
  always_comb begin
    next_state = state;
    case (state)
      ST_TLR:       next_state = tms_s ? ST_TLR : ST_IDLE;
      ST_IDLE:      next_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:    next_state = tms_s ? ST_SEL_IR : ST_CAPT_DR;
      ST_CAPT_DR:   next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:  next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:  next_state = tms_s ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:  next_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:  next_state = tms_s ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:    next_state = tms_s ? ST_TLR : ST_CAPT_IR;
      ST_CAPT_IR:   next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:  next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:  next_state = tms_s ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:  next_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:  next_state = tms_s ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
      default:      next_state = ST_TLR;
    endcase
  end

  // Controller state; a disabled port holds it in reset
  always_ff @(posedge clk) begin
    if (sys_rst || !port_active) state <= ST_TLR;
    else if (tck_rise) state <= next_state;
  end

  // Instruction register, four bits shifted LSB first
  always_ff @(posedge clk) begin
    if (sys_rst || state == ST_TLR) begin
      ir    <= `JDB_IR_IDCODE;
      ir_sr <= `JDB_IR_CAPTURE;
    end else if (tck_rise) begin
      if (state == ST_CAPT_IR) ir_sr <= `JDB_IR_CAPTURE;
      else if (state == ST_SHIFT_IR) ir_sr <= {tdi_s, ir_sr[3:1]};
      else if (state == ST_UPDATE_IR) ir <= ir_sr;
    end
  end

  // Private ops 0 to 2 fall back to bypass unless debug is allowed; op 3, programming, needs only an active port
  always_comb begin
    case (ir)
      `JDB_IR_EXTEST, `JDB_IR_IDCODE, `JDB_IR_SAMPLE, `JDB_IR_DEV_RESET:
        eff_ir = ir;
      `JDB_IR_DBG_OP0, `JDB_IR_DBG_OP1, `JDB_IR_DBG_OP2:
        eff_ir = debug_active ? ir : `JDB_IR_BYPASS;
      `JDB_IR_DBG_OP3:
        eff_ir = port_active ? ir : `JDB_IR_BYPASS;
      default: eff_ir = `JDB_IR_BYPASS;
    endcase
  end

  assign capt_dr  = tck_rise && state == ST_CAPT_DR;
  assign shift_dr = tck_rise && state == ST_SHIFT_DR;
  assign upd_dr   = tck_rise && state == ST_UPDATE_DR;

  // Boundary cells per pin: input, output data, output control
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_bsc
      assign bsr_cap[3*gi]   = pin_s[gi];
      assign bsr_cap[3*gi+1] = core_out[gi];
      assign bsr_cap[3*gi+2] = core_oe[gi];
    end
  endgenerate

  // Public data registers: bypass, identification, reset, boundary chain
  always_ff @(posedge clk) begin
    if (sys_rst || state == ST_TLR) begin
      bypass_sr <= 1'b0;
      id_sr     <= ID_VALUE;
      rst_sr    <= 1'b0;
      bsr       <= '0;
    end else if (capt_dr) begin
      bypass_sr <= 1'b0;
      id_sr     <= ID_VALUE;
      if (eff_ir == `JDB_IR_EXTEST || eff_ir == `JDB_IR_SAMPLE) bsr <= bsr_cap;
    end else if (shift_dr) begin
      case (eff_ir)
        `JDB_IR_IDCODE:    id_sr <= {tdi_s, id_sr[31:1]};
        `JDB_IR_DEV_RESET: rst_sr <= tdi_s;
        `JDB_IR_EXTEST, `JDB_IR_SAMPLE: bsr <= {tdi_s, bsr[BSR_W-1:1]};
        `JDB_IR_BYPASS:    bypass_sr <= tdi_s;
        default:           bypass_sr <= bypass_sr;
      endcase
    end
  end

  // Output latches of the chain, loaded under either boundary instruction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ul_dat <= '0;
      ul_ctl <= '0;
    end else if (upd_dr && (eff_ir == `JDB_IR_EXTEST || eff_ir == `JDB_IR_SAMPLE)) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        ul_dat[i] <= bsr[3*i+1];
        ul_ctl[i] <= bsr[3*i+2];
      end
    end
  end

  // Pin drive; reset value leaves every pin floating
  assign extest_on   = port_active && eff_ir == `JDB_IR_EXTEST;
  assign dev_rst_int = !rst_n_s || (port_active && eff_ir == `JDB_IR_DEV_RESET && rst_sr);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out   <= '0;
      pin_oe_n  <= '1;
      dev_reset <= 1'b1;
    end else begin
      dev_reset <= dev_rst_int;
      if (extest_on) begin
        pin_out  <= ul_dat;
        pin_oe_n <= ~ul_ctl;
      end else begin
        pin_out  <= core_out;
        pin_oe_n <= dev_rst_int ? '1 : ~core_oe;
      end
    end
  end

  // Private chains: instruction injection, mailbox read, break point setup, programming
  always_ff @(posedge clk) begin
    if (sys_rst || state == ST_TLR) begin
      cpu_sr  <= '0;
      comm_sr <= '0;
      bp_sr   <= '0;
      prog_sr <= '0;
    end else if (capt_dr) begin
      cpu_sr  <= '0;
      comm_sr <= {dirty, comm_byte};
      bp_sr   <= bp_cfg;
      prog_sr <= '0;
    end else if (shift_dr) begin
      case (eff_ir)
        `JDB_IR_DBG_OP0: cpu_sr <= {tdi_s, cpu_sr[15:1]};
        `JDB_IR_DBG_OP1: comm_sr <= {tdi_s, comm_sr[8:1]};
        `JDB_IR_DBG_OP2: bp_sr <= {tdi_s, bp_sr[`JDB_BP_CFG_W-1:1]};
        `JDB_IR_DBG_OP3: prog_sr <= {tdi_s, prog_sr[`JDB_PROG_W-1:1]};
        default:         cpu_sr <= cpu_sr;
      endcase
    end
  end

  // Injected instruction handed to the CPU as a one-cycle strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_instr       <= '0;
      cpu_instr_valid <= 1'b0;
    end else begin
      cpu_instr_valid <= upd_dr && eff_ir == `JDB_IR_DBG_OP0;
      if (upd_dr && eff_ir == `JDB_IR_DBG_OP0) cpu_instr <= cpu_sr;
    end
  end

  // Break point configuration, only written while debug is allowed
  always_ff @(posedge clk) begin
    if (sys_rst) bp_cfg <= '0;
    else if (upd_dr && eff_ir == `JDB_IR_DBG_OP2) bp_cfg <= bp_sr;
  end

  // Mailbox reaches the CPU only when fuse and debugger both allow it
  assign comm_route = debug_enable_fuse && bp_cfg[`JDB_BP_COMM_EN];

  // Mailbox byte and dirty flag; a CPU write wins over the debugger's clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      comm_byte <= '0;
      dirty     <= 1'b0;
    end else if (cpu_comm_wr && comm_route) begin
      comm_byte <= cpu_comm_wdata;
      dirty     <= 1'b1;
    end else if (upd_dr && eff_ir == `JDB_IR_DBG_OP1) begin
      dirty <= 1'b0;
    end
  end

  // CPU read data and redirection to the ordinary I/O location
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_comm_rdata <= '0;
      io_ordinary_wr <= 1'b0;
      io_ordinary_rd <= 1'b0;
    end else begin
      io_ordinary_wr <= cpu_comm_wr && !comm_route;
      io_ordinary_rd <= cpu_comm_rd && !comm_route;
      if (cpu_comm_rd && comm_route) cpu_comm_rdata <= {dirty, comm_byte[6:0]};
    end
  end

  // Break comparators; the layout decides whether points two and three watch data
  assign bp_mode   = bp_cfg[`JDB_BP_MODE_LSB+1:`JDB_BP_MODE_LSB];
  assign range_hit = bp_cfg[`JDB_BP_RANGE_DATA]
                   ? cpu_dvalid && ((cpu_daddr ^ bp_cfg[47:32]) & ~bp_cfg[63:48]) == 16'h0000
                   : cpu_fetch && ((cpu_pc ^ bp_cfg[47:32]) & ~bp_cfg[63:48]) == 16'h0000;
  always_comb begin
    bp_hit[0] = cpu_fetch && cpu_pc == bp_cfg[15:0];
    bp_hit[1] = cpu_fetch && cpu_pc == bp_cfg[31:16];
    case (bp_mode)
      `JDB_BP_MODE_4P: begin
        bp_hit[2] = cpu_fetch && cpu_pc == bp_cfg[47:32];
        bp_hit[3] = cpu_fetch && cpu_pc == bp_cfg[63:48];
      end
      `JDB_BP_MODE_3P1D: begin
        bp_hit[2] = cpu_fetch && cpu_pc == bp_cfg[47:32];
        bp_hit[3] = cpu_dvalid && cpu_daddr == bp_cfg[63:48];
      end
      `JDB_BP_MODE_2P2D: begin
        bp_hit[2] = cpu_dvalid && cpu_daddr == bp_cfg[47:32];
        bp_hit[3] = cpu_dvalid && cpu_daddr == bp_cfg[63:48];
      end
      default: begin
        bp_hit[2] = range_hit;
        bp_hit[3] = 1'b0;
      end
    endcase
  end

  // Halt request to the CPU
  always_ff @(posedge clk) begin
    if (sys_rst) break_req <= 1'b0;
    else break_req <= debug_active && ((|bp_hit)
                   || (bp_cfg[`JDB_BP_FLOW_EN] && cpu_flow_change)
                   || (bp_cfg[`JDB_BP_STEP_EN] && cpu_fetch));
  end

  // Programming commands; debug fuse write refused on a locked, unerased part
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prog_cmd     <= '0;
      prog_data    <= '0;
      prog_valid   <= 1'b0;
      prog_refused <= 1'b0;
      erased       <= 1'b0;
    end else begin
      prog_valid   <= 1'b0;
      prog_refused <= 1'b0;
      if (upd_dr && eff_ir == `JDB_IR_DBG_OP3) begin
        if (prog_sr[7:0] == `JDB_CMD_CHIP_ERASE) erased <= 1'b1;
        if (prog_sr[7:0] == `JDB_CMD_DBG_FUSE && locked && !erased) begin
          prog_refused <= 1'b1;
        end else begin
          prog_cmd   <= prog_sr[7:0];
          prog_data  <= prog_sr[23:8];
          prog_valid <= 1'b1;
        end
      end
    end
  end

  // Serial output changes on the falling test clock edge
  always_comb begin
    case (eff_ir)
      `JDB_IR_IDCODE:    next_tdo = id_sr[0];
      `JDB_IR_EXTEST, `JDB_IR_SAMPLE: next_tdo = bsr[0];
      `JDB_IR_DEV_RESET: next_tdo = rst_sr;
      `JDB_IR_DBG_OP0:   next_tdo = cpu_sr[0];
      `JDB_IR_DBG_OP1:   next_tdo = comm_sr[0];
      `JDB_IR_DBG_OP2:   next_tdo = bp_sr[0];
      `JDB_IR_DBG_OP3:   next_tdo = prog_sr[0];
      default:           next_tdo = bypass_sr;
    endcase
    if (state == ST_SHIFT_IR) next_tdo = ir_sr[0];
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tdo      <= 1'b1;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo      <= next_tdo;
      tdo_oe_n <= !(state == ST_SHIFT_IR || state == ST_SHIFT_DR);
    end
  end

  AST_IR_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_TLR |=> ir == `JDB_IR_IDCODE) else $error("ir not default after reset state");
  AST_BYPASS_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    capt_dr && eff_ir == `JDB_IR_BYPASS |=> !bypass_sr) else $error("bypass not cleared");
  AST_PORT_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    !port_active |=> state == ST_TLR) else $error("disabled port left reset state");
  AST_DIRTY_SET: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_comm_wr && comm_route |=> dirty && comm_byte == $past(cpu_comm_wdata))
    else $error("mailbox write lost");
  AST_READ_BACK: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_comm_rd && comm_route |=> cpu_comm_rdata == {$past(dirty), $past(comm_byte[6:0])})
    else $error("mailbox read data wrong");
  AST_DIRTY_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    upd_dr && eff_ir == `JDB_IR_DBG_OP1 && !(cpu_comm_wr && comm_route) |=> !dirty)
    else $error("dirty not cleared by debugger read");
  AST_PIN_RESET: assert property (@(posedge clk) disable iff (sys_rst)
    !rst_n_s |=> dev_reset) else $error("reset pin did not reset device");
  AST_HIGHZ: assert property (@(posedge clk) disable iff (sys_rst)
    dev_rst_int && !extest_on |=> &pin_oe_n) else $error("pins driven during reset");
  AST_LOCK_NO_BREAK: assert property (@(posedge clk) disable iff (sys_rst)
    locked ##1 locked |-> !break_req) else $error("break while locked");
  AST_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    debug_active && bp_cfg[`JDB_BP_STEP_EN] && cpu_fetch |=> break_req)
    else $error("single step missed");
  AST_FUSE_REFUSE: assert property (@(posedge clk) disable iff (sys_rst)
    upd_dr && eff_ir == `JDB_IR_DBG_OP3 && prog_sr[7:0] == `JDB_CMD_DBG_FUSE && locked
    && !erased |=> prog_refused && !prog_valid) else $error("locked fuse write accepted");
  AST_EXTEST_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    extest_on |=> pin_out == $past(ul_dat)) else $error("latches not driven in external test");

endmodule

//--- verification/jdb_jtag_host.sv
`timescale 1ns/100ps
module jdb_jtag_host (
  // Test access pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // Test clock rests low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock period; tdo is read late in the high phase, where it still stands
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #200 tck = 1'b1;
    #190 q = tdo;
    #10 tck = 1'b0;
  endtask

  // Scan from Idle back to Idle; LSB goes first
  task automatic scan(input logic ir, input int n, input logic [69:0] din,
                      output logic [69:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    // Leave through Update and return to Idle
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] ID = 32'hA5C3_0F01;  // Arbitrary value, LSB set
  logic        clk, sys_rst, tck, tms, tdi, tdo, dev_reset, ext_reset_n, en_fuse, dbg_fuse;
  logic        lock1, lock2, dis_bit, wr, rd, io_wr, pv, pr;
  logic        tdo_oe_n, tdo_line, io_rd, iv, fetch, flow, brk_q;
  logic [7:0]  pin_in, core_out, core_oe, pin_oe_n, wdata, rdata, b, pout, pcmd;
  logic [15:0] cinstr, cpu_pc, pdat, pd, w, a;
  logic [23:0] v;
  logic [69:0] q;
  int          err_count, checked, n_valid, n_refused, n_instr;

  // Serial output line has a pull-up, so a released driver reads as one
  assign tdo_line = tdo_oe_n ? 1'b1 : tdo;
  jdb_jtag_host i_jdb_jtag_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
  jdb_tap #(.ID_VALUE(ID)) i_jdb_tap (
    .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .test_port_enable_fuse(en_fuse), .debug_enable_fuse(dbg_fuse),
    .lock_bit_one(lock1), .lock_bit_two(lock2), .test_port_disable_bit(dis_bit),
    .ext_reset_n(ext_reset_n), .dev_reset(dev_reset), .pin_in(pin_in),
    .core_out(core_out), .core_oe(core_oe), .pin_out(pout), .pin_oe_n(pin_oe_n),
    .cpu_comm_wr(wr), .cpu_comm_rd(rd), .cpu_comm_wdata(wdata), .cpu_comm_rdata(rdata),
    .io_ordinary_wr(io_wr), .io_ordinary_rd(io_rd), .cpu_instr(cinstr), .cpu_instr_valid(iv),
    .cpu_pc(cpu_pc), .cpu_fetch(fetch), .cpu_flow_change(flow), .cpu_daddr(16'h0000),
    .cpu_dvalid(1'b0), .break_req(brk_q), .prog_cmd(pcmd), .prog_data(pdat), .prog_valid(pv),
    .prog_refused(pr));

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Programming and instruction-injection pulses last one cycle, so they are counted as they pass
  always @(posedge clk) begin
    n_valid <= n_valid + (pv === 1'b1);
    n_refused <= n_refused + (pr === 1'b1);
    n_instr <= n_instr + (iv === 1'b1);
  end

  // Expected CPU view of the mailbox
  function automatic logic [7:0] mbox_exp(input logic [7:0] v, input logic dirty);
    return {dirty, v[6:0]};
  endfunction

  // Boundary chain capture: per pin input, output data, output control
  function automatic logic [23:0] bsr_exp(input logic [7:0] p, o, e);
    logic [23:0] r;
    for (int i = 0; i < 8; i++) r[3*i +: 3] = {e[i], o[i], p[i]};
    return r;
  endfunction

  // Pin data and active-low enables driven from preloaded latches
  function automatic logic [15:0] drive_exp(input logic [23:0] v);
    logic [7:0] d, c;
    for (int i = 0; i < 8; i++) begin
      d[i] = v[3*i+1];
      c[i] = ~v[3*i+2];
    end
    return {d, c};
  endfunction

  // One-cycle CPU fetch or flow-change event; break request checked a cycle on
  task automatic brk(input logic [15:0] pc, input logic f, input logic fl);
    @(negedge clk);
    cpu_pc = pc;
    fetch = f;
    flow = fl;
    @(negedge clk);
    fetch = 1'b0;
    flow = 1'b0;
  endtask

  task automatic chk(input logic [69:0] got, input logic [69:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle CPU strobe, checked on the settled next cycle
  task automatic cpu(input logic w, input logic [7:0] d);
    @(negedge clk);
    wr = w;
    rd = ~w;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask

  task automatic prog(input logic [7:0] cmd);
    pd = 16'($urandom);
    i_jdb_jtag_host.scan(1'b1, 4, 70'hB, q);
    i_jdb_jtag_host.scan(1'b0, 24, {46'h0, pd, cmd}, q);
    repeat (4) @(negedge clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 0.16 ms
  initial begin
    #3_000_000;
    err_count++;
    complete_run();
  end

  initial begin
    logic qb;
    err_count = 0; checked = 0; n_valid = 0; n_refused = 0;
    sys_rst = 1'b1; ext_reset_n = 1'b1; en_fuse = 1'b1; dbg_fuse = 1'b1;
    lock1 = 1'b0; lock2 = 1'b0; dis_bit = 1'b0; wr = 1'b0; rd = 1'b0;
    n_instr = 0;
    fetch = 1'b0;
    flow = 1'b0;
    cpu_pc = 16'h0000;
    void'($urandom(10248));
    pin_in = 8'($urandom); core_out = 8'($urandom); core_oe = 8'($urandom);
    wdata = 8'h00;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    i_jdb_jtag_host.step(1'b0, 1'b0, qb);
    i_jdb_jtag_host.scan(1'b0, 32, 70'h0, q);
    chk(q[31:0], ID);
    $display("identification test done");
    i_jdb_jtag_host.scan(1'b1, 4, 70'hF, q);
    chk(q[3:0], 4'h1);
    b = 8'($urandom);
    i_jdb_jtag_host.scan(1'b0, 8, {62'h0, b}, q);
    chk(q[7:0], {b[6:0], 1'b0});
    $display("bypass test done");
    v = 24'($urandom);
    i_jdb_jtag_host.scan(1'b1, 4, 70'h2, q);
    i_jdb_jtag_host.scan(1'b0, 24, {46'h0, v}, q);
    chk(q[23:0], bsr_exp(pin_in, core_out, core_oe));
    chk({pout, pin_oe_n}, {core_out, ~core_oe});
    i_jdb_jtag_host.scan(1'b1, 4, 70'h0, q);
    chk({pout, pin_oe_n}, drive_exp(v));
    $display("boundary test done");
    cpu(1'b1, b);
    chk(io_wr, 1'b1);
    cpu(1'b0, 8'h00);
    chk(io_rd, 1'b1);
    a = 16'($urandom) | 16'h8000;
    i_jdb_jtag_host.scan(1'b1, 4, 70'hA, q);
    i_jdb_jtag_host.scan(1'b0, 70, {3'b101, 51'h0, a}, q);
    b = 8'($urandom) | 8'h80;
    cpu(1'b1, b);
    chk(io_wr, 1'b0);
    cpu(1'b0, 8'h00);
    chk(rdata, mbox_exp(b, 1'b1));
    i_jdb_jtag_host.scan(1'b1, 4, 70'h9, q);
    i_jdb_jtag_host.scan(1'b0, 9, 70'h0, q);
    chk(q[8:0], {1'b1, b});
    cpu(1'b0, 8'h00);
    chk(rdata, mbox_exp(b, 1'b0));
    $display("mailbox test done");
    brk(a, 1'b1, 1'b0);
    chk(brk_q, 1'b1);
    brk(a ^ 16'h0001, 1'b1, 1'b0);
    chk(brk_q, 1'b0);
    brk(a ^ 16'h0001, 1'b0, 1'b1);
    chk(brk_q, 1'b1);
    w = 16'($urandom);
    i_jdb_jtag_host.scan(1'b1, 4, 70'h8, q);
    i_jdb_jtag_host.scan(1'b0, 16, {54'h0, w}, q);
    chk({n_instr[7:0], cinstr}, {8'h01, w});
    $display("debug test done");
    i_jdb_jtag_host.scan(1'b1, 4, 70'hC, q);
    i_jdb_jtag_host.scan(1'b0, 1, 70'h1, q);
    chk(dev_reset, 1'b1);
    chk(pin_oe_n, 8'hFF);
    i_jdb_jtag_host.scan(1'b0, 1, 70'h0, q);
    repeat (2) @(negedge clk);
    chk(dev_reset, 1'b0);
    ext_reset_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(dev_reset, 1'b1);
    ext_reset_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(dev_reset, 1'b0);
    $display("reset test done");
    lock1 = 1'b1;
    brk(a, 1'b1, 1'b0);
    chk(brk_q, 1'b0);
    prog(8'h40);
    chk({n_valid[7:0], n_refused[7:0]}, 16'h0001);
    prog(8'h80);
    prog(8'h40);
    chk({n_valid[7:0], n_refused[7:0]}, 16'h0201);
    chk({pcmd, pdat}, {8'h40, pd});
    $display("programming test done");
    complete_run();
  end
endmodule
